// ---- dv/stp_sorter_model.sv ----
// behavioural model of the sorting system that drives the trigger line
`timescale 1ns/100ps
module stp_sorter_model (
  input wire logic aclk,
  output logic trig_n
);
  // ====
  // trigger line, pulled up while the sorter is idle
  initial trig_n = 1'b1;
  // one trigger: fall just after an edge, hold low, then release to the pull-up
  // a long low_cyc models a slow sorter; the caller never goes below the minimum
  // trigger held low for at least the minimum width
  task automatic pulse(input int low_cyc);
    @(posedge aclk);
    trig_n <= 1'b0;
    repeat (low_cyc) @(posedge aclk);
    trig_n <= 1'b1;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the sorter trigger and result port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  // ====
  // clock, reset and design hookup
  localparam int TRIG_CYC = 20; // shortened minimum trigger low time
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, meas_value;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic trig_n, bin_one_good_n, bin_two_good_n, bin_three_good_n, reject_n, meas_done_n;
  logic meas_start, meas_ready, irq;
  logic [31:0] lim [4] = '{32'h64, 32'hc8, 32'h12c, 32'h190}; // low, bin1, bin2, bin3 upper
  logic [31:0] corner [8] = '{32'h63, 32'h64, 32'hc8, 32'hc9, 32'h12c, 32'h190, 32'h191, 32'h0};
  int fails = 0;
  int samples_checked = 0;
  int starts = 0; // measurement start pulses seen
  always #10 aclk = ~aclk; // 50 MHz
  always @(posedge aclk) if (meas_start === 1'b1) starts <= starts + 1;
  stp_sorter_port #(.TRIG_MIN_CYC(TRIG_CYC)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .trig_n, .bin_one_good_n, .bin_two_good_n,
    .bin_three_good_n, .reject_n, .meas_done_n, .meas_start, .meas_ready, .meas_value, .irq
  );
  stp_sorter_model sorter (.aclk, .trig_n);
  // ====
  // verdict and end of run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a wait that ran out counts as a mismatch
  task automatic hang(input string nm);
    fails++;
    $display("[ERR] %s exp answer got timeout", nm);
    end_of_test();
  endtask
  // bounded wait for meas_start (sel 0) or meas_done_n (sel 1) to reach a level
  task automatic wait_for(input string nm, input bit sel, input logic lvl);
    for (int n = 0; n < 300; n++) begin
      @(posedge aclk);
      if ((sel ? meas_done_n : meas_start) === lvl) return;
    end
    hang(nm);
  endtask
  // ====
  // bus master: both write halves offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 300) hang("bvalid");
  endtask
  // read one word; data and response taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    if (n == 300) hang("rvalid");
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(nm, e, d)
  endtask
  // ====
  // expected {bin1, bin2, bin3, reject} lines, inclusive limits, first bin wins
  function automatic logic [3:0] exp_lines(input logic [31:0] v);
    if (v < lim[0] || v > lim[3]) return 4'b1110;
    if (v <= lim[1]) return 4'b0111;
    if (v <= lim[2]) return 4'b1011;
    return 4'b1101;
  endfunction
  // one trigger from the sorter; the core answers after a random delay
  task automatic meas_chk(input logic [31:0] v);
    logic [3:0] e;
    e = exp_lines(v);
    fork
      sorter.pulse(TRIG_CYC + $urandom_range(0, 10));
      begin
        wait_for("meas_start", 1'b0, 1'b1);
        `CHK("lines at start", 5'h1f, {bin_one_good_n, bin_two_good_n, bin_three_good_n, reject_n, meas_done_n})
        repeat ($urandom_range(0, 4)) @(posedge aclk);
        {meas_ready, meas_value} <= {1'b1, v};
        @(posedge aclk);
        meas_ready <= 1'b0;
        wait_for("meas_done_n", 1'b1, 1'b0);
      end
    join
    `CHK("result lines", e, {bin_one_good_n, bin_two_good_n, bin_three_good_n, reject_n})
    `CHK("end of measurement", 1'b0, meas_done_n)
    `CHK("irq", ~e[0], irq)
    rd_chk("status", stp_pkg::OFF_IRQ_STS, {30'h0, ~e[0], 1'b1});
    `CHK("irq after status read", 1'b0, irq)
    rd_chk("value", stp_pkg::OFF_VALUE, v);
  endtask
  // ====
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h0d89));
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
    {araddr, arvalid, rready, meas_ready, meas_value} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk("ctrl reset", stp_pkg::OFF_CTRL, 32'h0);
    rd_chk("file reset", stp_pkg::OFF_FILE, 32'h0);
    rd_chk("mask reset", stp_pkg::OFF_IRQ_MSK, 32'h0);
    axi_rd(8'h20, d, r);
    `CHK("unmapped resp", stp_pkg::RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    // internal mode after reset: the pin must not start anything
    sorter.pulse(TRIG_CYC + 5);
    repeat (10) @(posedge aclk);
    `CHK("starts in internal mode", 0, starts)
    // limits only in file 2, so a design reading file 0 rejects every part but zero
    for (int i = 0; i < 4; i++) begin
      axi_wr(stp_pkg::OFF_LIM_BASE + 8'h20 + 8'(i * 4), lim[i]);
    end
    axi_wr(stp_pkg::OFF_FILE, 32'h2);
    axi_wr(stp_pkg::OFF_IRQ_MSK, 32'h2); // only the fail event reaches irq
    axi_wr(stp_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 24; i++) begin
      meas_chk((i < 8) ? corner[i] : 32'($urandom_range(0, 500)));
    end
    // back to file 0, all limits zero: only zero is a good part
    axi_wr(stp_pkg::OFF_FILE, 32'h0);
    lim = '{default: 32'h0};
    meas_chk(32'h0);
    meas_chk(32'h1);
    // internal mode: a soft trigger starts, a second one while busy is dropped
    axi_wr(stp_pkg::OFF_CTRL, 32'h0);
    axi_wr(stp_pkg::OFF_CTRL, 32'h2);
    axi_wr(stp_pkg::OFF_CTRL, 32'h2);
    rd_chk("busy status", stp_pkg::OFF_STAT,
           (32'(stp_pkg::BIN_FAIL) << stp_pkg::STAT_CODE_LSB) | 32'h1);
    {meas_ready, meas_value} <= {1'b1, 32'h0};
    @(posedge aclk);
    meas_ready <= 1'b0;
    wait_for("soft done", 1'b1, 1'b0);
    `CHK("soft result", exp_lines(32'h0), {bin_one_good_n, bin_two_good_n, bin_three_good_n, reject_n})
    rd_chk("lost status", stp_pkg::OFF_IRQ_STS,
           (32'h1 << stp_pkg::IRQ_LOST_BIT) | (32'h1 << stp_pkg::IRQ_DONE_BIT));
    // one start pulse for every accepted trigger, none for the dropped one
    `CHK("starts per trigger", 27, starts)
    end_of_test();
  end
endmodule

// ---- hw/stp_axil_slave.sv ----
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/100ps
module stp_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_stb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  // =====================================================================
  // write path
  logic aw_held_ff; // address captured, waiting for data
  logic w_held_ff; // data captured, waiting for address
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_stb_ff;

  // no new write is taken while a response is pending: one write at a time
  assign awready = !aw_held_ff && !bvalid_ff && !wr_stb_ff;
  assign wready = !w_held_ff && !bvalid_ff && !wr_stb_ff;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      wr_stb_ff <= 1'b0;
    end else begin
      wr_stb_ff <= 1'b0;
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      // both halves present: fire one strobe and free the holders
      if (aw_held_ff && w_held_ff) begin
        wr_stb_ff <= 1'b1;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
    end
  end

  // response raised the cycle after the strobe, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= stp_pkg::RESP_OKAY;
    end else if (wr_stb_ff) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? stp_pkg::RESP_SLVERR : stp_pkg::RESP_OKAY;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign wr_stb = wr_stb_ff;
  assign wr_addr = aw_addr_ff;
  assign wr_data = w_data_ff;
  assign wr_strb = w_strb_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // =====================================================================
  // read path: data sampled in the address handshake cycle
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign arready = !rvalid_ff;
  assign rd_stb = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= stp_pkg::RESP_OKAY;
    end else if (rd_stb) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_err ? stp_pkg::RESP_SLVERR : stp_pkg::RESP_OKAY;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
endmodule

// ---- hw/stp_pkg.sv ----
// shared constants, types and register map of the sorter trigger/result port
package stp_pkg;
  // =====================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // mode select, soft trigger
  localparam logic [7:0] OFF_FILE = 8'h04; // selected comparison file
  localparam logic [7:0] OFF_STAT = 8'h08; // busy, result code
  localparam logic [7:0] OFF_VALUE = 8'h0c; // last measured value
  localparam logic [7:0] OFF_IRQ_STS = 8'h10; // sticky events, read clears
  localparam logic [7:0] OFF_IRQ_MSK = 8'h14; // interrupt mask
  localparam logic [7:0] OFF_LIM_BASE = 8'h40; // limit words, 4 per file
  localparam logic [7:0] OFF_LIM_LAST = 8'h7c;
  // =====================================================================
  // field positions
  localparam int CTRL_EXT_BIT = 0; // 1: external trigger mode
  localparam int CTRL_SOFT_BIT = 1; // write 1: internal trigger
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CODE_LSB = 1; // two-bit result code
  localparam int IRQ_DONE_BIT = 0; // measurement finished
  localparam int IRQ_FAIL_BIT = 1; // part rejected
  localparam int IRQ_LOST_BIT = 2; // trigger while busy
  localparam int IRQ_SHORT_BIT = 3; // trigger pulse too short
  localparam int IRQ_W = 4;
  localparam int FILE_W = 2;
  localparam int NUM_LIMS = 16; // 4 files x 4 limits
  localparam logic [1:0] LIM_LOW = 2'h0; // lower limit of every bin
  localparam logic [1:0] LIM_BIN1 = 2'h1; // upper limit bin 1
  localparam logic [1:0] LIM_BIN2 = 2'h2; // upper limit bin 2
  localparam logic [1:0] LIM_BIN3 = 2'h3; // upper limit bin 3
  // =====================================================================
  // reset values
  localparam logic CTRL_EXT_RST = 1'h0;
  localparam logic [FILE_W-1:0] FILE_RST = 2'h0;
  localparam logic [IRQ_W-1:0] MSK_RST = 4'h0;
  localparam logic [31:0] LIM_RST = 32'h0000_0000;
  // =====================================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TRIG_MIN_MS = 10; // least trigger low time
  localparam int TRIG_MIN_CYC = (CLK_HZ / 1000) * TRIG_MIN_MS;
  localparam int LOWCNT_W = 20;
  // =====================================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================================
  // types
  typedef enum logic [1:0] {BIN_ONE, BIN_TWO, BIN_THREE, BIN_FAIL} stp_bin_e;
  typedef struct packed {
    logic bin1_n;
    logic bin2_n;
    logic bin3_n;
    logic reject_n;
    logic eoc_n;
  } stp_pins_s;
  localparam stp_pins_s PINS_IDLE = 5'h1f; // all lines released high
endpackage

// ---- hw/stp_sorter_port.sv ----
// sorter port: trigger input, bin/reject/end-of-measurement outputs, registers
// What this block does
// - three bin outputs, low marks that bin
// - reject output low on fail, else high
// - end-of-measurement output low when finished
// - result compared against selected file limits
`timescale 1ns/100ps
module stp_sorter_port #(
  parameter int TRIG_MIN_CYC = stp_pkg::TRIG_MIN_CYC // shorten in simulation
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic trig_n, // pin from the sorter, asynchronous
  output logic bin_one_good_n,
  output logic bin_two_good_n,
  output logic bin_three_good_n,
  output logic reject_n,
  output logic meas_done_n,
  output logic meas_start, // pulse to the measuring core
  input wire logic meas_ready, // core result strobe
  input wire logic [31:0] meas_value,
  output logic irq
);
  // =====================================================================
  // functions
  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction
  // true for every mapped, word-aligned offset
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == stp_pkg::OFF_CTRL) || (a == stp_pkg::OFF_FILE) || (a == stp_pkg::OFF_STAT) ||
           (a == stp_pkg::OFF_VALUE) || (a == stp_pkg::OFF_IRQ_STS) || (a == stp_pkg::OFF_IRQ_MSK) ||
           (a >= stp_pkg::OFF_LIM_BASE && a <= stp_pkg::OFF_LIM_LAST && a[1:0] == 2'h0);
  endfunction
  // sort a value into a bin; below the low limit or above bin 3 fails
  function automatic stp_pkg::stp_bin_e classify(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] h1,
                                                 input logic [31:0] h2, input logic [31:0] h3);
    stp_pkg::stp_bin_e b;
    if (v < lo) b = stp_pkg::BIN_FAIL;
    else if (v <= h1) b = stp_pkg::BIN_ONE;
    else if (v <= h2) b = stp_pkg::BIN_TWO;
    else if (v <= h3) b = stp_pkg::BIN_THREE;
    else b = stp_pkg::BIN_FAIL;
    return b;
  endfunction

  // =====================================================================
  // bus slave
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_stb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  stp_axil_slave u_bus (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_err(!addr_ok(wr_addr)), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(!addr_ok(rd_addr))
  );

  // =====================================================================
  // trigger pin synchroniser and edge detect
  logic trig_meta_ff; // first stage, read only by the second
  logic trig_sync_ff;
  logic trig_prev_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_meta_ff <= 1'b1;
      trig_sync_ff <= 1'b1;
      trig_prev_ff <= 1'b1;
    end else begin
      trig_meta_ff <= trig_n;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end
  wire logic trig_fall = trig_prev_ff && !trig_sync_ff; // one-cycle pulse per synced fall
  wire logic trig_rise = !trig_prev_ff && trig_sync_ff;

  // =====================================================================
  // control registers
  logic ctrl_ext_ff; // external trigger mode
  logic [stp_pkg::FILE_W-1:0] file_ff; // selected comparison file
  logic [stp_pkg::IRQ_W-1:0] msk_ff;
  logic [31:0] lim_mem [stp_pkg::NUM_LIMS]; // limit words of all files
  logic [31:0] ctrl_word;
  assign ctrl_word = merge({31'h0000_0000, ctrl_ext_ff}, wr_data, wr_strb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ext_ff <= stp_pkg::CTRL_EXT_RST;
      file_ff <= stp_pkg::FILE_RST;
      msk_ff <= stp_pkg::MSK_RST;
    end else if (wr_stb) begin
      if (wr_addr == stp_pkg::OFF_CTRL) ctrl_ext_ff <= ctrl_word[stp_pkg::CTRL_EXT_BIT];
      if (wr_addr == stp_pkg::OFF_FILE) begin
        file_ff <= stp_pkg::FILE_W'(merge({30'h0000_0000, file_ff}, wr_data, wr_strb));
      end
      if (wr_addr == stp_pkg::OFF_IRQ_MSK) begin
        msk_ff <= stp_pkg::IRQ_W'(merge({28'h000_0000, msk_ff}, wr_data, wr_strb));
      end
    end
  end

  // limit words; no reset-time loop over the array beyond a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < stp_pkg::NUM_LIMS; i++) lim_mem[i] <= stp_pkg::LIM_RST;
    end else if (wr_stb && addr_ok(wr_addr) && wr_addr >= stp_pkg::OFF_LIM_BASE) begin
      lim_mem[wr_addr[5:2]] <= merge(lim_mem[wr_addr[5:2]], wr_data, wr_strb);
    end
  end

  // =====================================================================
  // measurement sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_RESULT, ST_HOLD} stp_state_e;
  stp_state_e state_ff;
  stp_pkg::stp_pins_s pins_ff; // registered pin levels
  stp_pkg::stp_bin_e code_ff; // last result code
  logic [31:0] value_ff;
  logic meas_start_ff;
  logic soft_trig;
  logic start_req;
  logic start_evt;
  logic lost_evt;
  stp_pkg::stp_bin_e cls;

  // soft trigger only counts in internal mode
  assign soft_trig = wr_stb && wr_addr == stp_pkg::OFF_CTRL && wr_strb[0] && !ctrl_ext_ff &&
                     wr_data[stp_pkg::CTRL_SOFT_BIT];
  assign start_req = ctrl_ext_ff ? trig_fall : soft_trig;
  // a trigger while busy is dropped and flagged, not queued
  assign start_evt = start_req && (state_ff == ST_IDLE || state_ff == ST_HOLD);
  assign lost_evt = start_req && !(state_ff == ST_IDLE || state_ff == ST_HOLD);
  assign cls = classify(meas_value, lim_mem[{file_ff, stp_pkg::LIM_LOW}], lim_mem[{file_ff, stp_pkg::LIM_BIN1}],
                        lim_mem[{file_ff, stp_pkg::LIM_BIN2}], lim_mem[{file_ff, stp_pkg::LIM_BIN3}]);

  // sequencer state and start pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      meas_start_ff <= 1'b0;
    end else begin
      meas_start_ff <= start_evt;
      unique case (state_ff)
        ST_IDLE, ST_HOLD: if (start_evt) state_ff <= ST_MEAS;
        ST_MEAS: if (meas_ready) state_ff <= ST_RESULT;
        ST_RESULT: state_ff <= ST_HOLD;
      endcase
    end
  end

  // pin levels: result set first, end strobe one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_ff <= stp_pkg::PINS_IDLE;
      code_ff <= stp_pkg::BIN_FAIL;
      value_ff <= 32'h0000_0000;
    end else if (start_evt) begin
      pins_ff <= stp_pkg::PINS_IDLE;
    end else if (state_ff == ST_MEAS && meas_ready) begin
      code_ff <= cls;
      value_ff <= meas_value;
      pins_ff.bin1_n <= (cls != stp_pkg::BIN_ONE);
      pins_ff.bin2_n <= (cls != stp_pkg::BIN_TWO);
      pins_ff.bin3_n <= (cls != stp_pkg::BIN_THREE);
      pins_ff.reject_n <= (cls != stp_pkg::BIN_FAIL);
    end else if (state_ff == ST_RESULT) begin
      pins_ff.eoc_n <= 1'b0;
    end
  end

  assign bin_one_good_n = pins_ff.bin1_n;
  assign bin_two_good_n = pins_ff.bin2_n;
  assign bin_three_good_n = pins_ff.bin3_n;
  assign reject_n = pins_ff.reject_n;
  assign meas_done_n = pins_ff.eoc_n;
  assign meas_start = meas_start_ff;

  // =====================================================================
  // trigger width monitor, flags pulses shorter than the sorter promises
  logic [stp_pkg::LOWCNT_W-1:0] low_cnt_ff;
  logic short_evt;
  assign short_evt = ctrl_ext_ff && trig_rise && (low_cnt_ff < TRIG_MIN_CYC[stp_pkg::LOWCNT_W-1:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_ff <= '0;
    end else if (trig_sync_ff) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != '1) begin
      low_cnt_ff <= low_cnt_ff + 1'b1; // saturates, never wraps back to short
    end
  end

  // =====================================================================
  // interrupt status: read clears, a same-cycle event wins
  logic [stp_pkg::IRQ_W-1:0] sts_ff;
  logic [stp_pkg::IRQ_W-1:0] set_bits;
  always_comb begin
    set_bits = '0;
    set_bits[stp_pkg::IRQ_DONE_BIT] = (state_ff == ST_RESULT);
    set_bits[stp_pkg::IRQ_FAIL_BIT] = (state_ff == ST_MEAS) && meas_ready && (cls == stp_pkg::BIN_FAIL);
    set_bits[stp_pkg::IRQ_LOST_BIT] = lost_evt;
    set_bits[stp_pkg::IRQ_SHORT_BIT] = short_evt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_ff <= '0;
    end else if (rd_stb && rd_addr == stp_pkg::OFF_IRQ_STS) begin
      sts_ff <= set_bits;
    end else begin
      sts_ff <= sts_ff | set_bits;
    end
  end
  assign irq = |(sts_ff & msk_ff);

  // =====================================================================
  // read data mux
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == stp_pkg::OFF_CTRL) rd_data[stp_pkg::CTRL_EXT_BIT] = ctrl_ext_ff;
    if (rd_addr == stp_pkg::OFF_FILE) rd_data[stp_pkg::FILE_W-1:0] = file_ff;
    if (rd_addr == stp_pkg::OFF_STAT) begin
      rd_data[stp_pkg::STAT_BUSY_BIT] = (state_ff == ST_MEAS) || (state_ff == ST_RESULT);
      rd_data[stp_pkg::STAT_CODE_LSB +: 2] = code_ff;
    end
    if (rd_addr == stp_pkg::OFF_VALUE) rd_data = value_ff;
    if (rd_addr == stp_pkg::OFF_IRQ_STS) rd_data[stp_pkg::IRQ_W-1:0] = sts_ff;
    if (rd_addr == stp_pkg::OFF_IRQ_MSK) rd_data[stp_pkg::IRQ_W-1:0] = msk_ff;
    if (addr_ok(rd_addr) && rd_addr >= stp_pkg::OFF_LIM_BASE) rd_data = lim_mem[rd_addr[5:2]];
  end

  // =====================================================================
  // assertions
  sequence s_result_in;
    (state_ff == ST_MEAS) && meas_ready && !start_evt;
  endsequence
  sequence s_result_out;
    pins_ff.eoc_n ##1 !pins_ff.eoc_n;
  endsequence

  AST_EXT_EDGE_START: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_ext_ff && trig_fall && state_ff == ST_IDLE) |=> (meas_start && state_ff == ST_MEAS))
    else $error("external trigger edge did not start a measurement");
  AST_ONE_BIN_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins_ff.eoc_n |-> ($countones({pins_ff.bin1_n, pins_ff.bin2_n, pins_ff.bin3_n, pins_ff.reject_n}) == 3))
    else $error("result lines not exactly one low at end of measurement");
  AST_REJECT_ON_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
    s_result_in |=> (pins_ff.reject_n == ($past(cls) != stp_pkg::BIN_FAIL)))
    else $error("reject line does not match comparison result");
  AST_EOC_AFTER_RESULT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_result_in |=> s_result_out)
    else $error("end of measurement not marked one cycle after the result");
  AST_FILE_COMPARE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_result_in |=> (code_ff == classify($past(meas_value), $past(lim_mem[{file_ff, stp_pkg::LIM_LOW}]),
      $past(lim_mem[{file_ff, stp_pkg::LIM_BIN1}]), $past(lim_mem[{file_ff, stp_pkg::LIM_BIN2}]),
      $past(lim_mem[{file_ff, stp_pkg::LIM_BIN3}]))))
    else $error("result code disagrees with selected file limits");
  AST_HOLD_UNTIL_TRIG: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pins_ff.eoc_n && !start_evt) |=> $stable(pins_ff))
    else $error("result lines changed without a new trigger");
  AST_RELEASE_ON_TRIG: assert property (@(posedge aclk) disable iff (!aresetn)
    start_evt |=> (pins_ff == stp_pkg::PINS_IDLE))
    else $error("result lines not released on a new measurement");
endmodule
